// File: design/fmc_consts.svh
`ifndef FMC_CONSTS_SVH
`define FMC_CONSTS_SVH

// control-register command codes
`define FMC_CMD_UNLOCK1     8'h73
`define FMC_CMD_UNLOCK2     8'h8c
`define FMC_CMD_PROTSEL     8'h5e
`define FMC_CMD_PAGE_ERASE  8'h95
`define FMC_CMD_MASS_ERASE  8'h63

// array organisation
`define FMC_PAGE_BYTES      512
`define FMC_PAGE_SHIFT      9
`define FMC_ROWS_PER_PAGE   8
`define FMC_ROW_BYTES       64
`define FMC_ROW_SHIFT       6
`define FMC_SECTORS         8
`define FMC_OPT_BYTES       2

// program memory ends per size variant, information area
`define FMC_END_4K          16'h0fff
`define FMC_END_2K          16'h07ff
`define FMC_END_1K          16'h03ff
`define FMC_PAGES_4K        4'h8
`define FMC_PAGES_2K        4'h4
`define FMC_PAGES_1K        4'h2
`define FMC_INFO_BASE       16'hfe00
`define FMC_INFO_END        16'hffff

// option byte 0 fields, programmed means zero
`define FMC_OPT_RP_BIT      7
`define FMC_OPT_WP_BIT      6
`define FMC_OPT_RESET       8'hff

// operation times in microseconds, and clock scale
`define FMC_PROG_US         40
`define FMC_PAGE_ERASE_US   10000
`define FMC_MASS_ERASE_US   200000
`define FMC_HZ_PER_KHZ      1000

`endif

// File: design/fmc_pkg.sv
package fmc_pkg;

    typedef enum logic [8:0] {
        ST_OPT0     = 9'h001,
        ST_OPT1     = 9'h002,
        ST_OPT2     = 9'h004,
        ST_LOCKED   = 9'h008,
        ST_GOT73    = 9'h010,
        ST_GOT8C    = 9'h020,
        ST_UNLOCKED = 9'h040,
        ST_PROTSEL  = 9'h080,
        ST_BUSY     = 9'h100
    } fmc_state_t;

    typedef enum logic [1:0] {
        OP_PROG = 2'h0,
        OP_PAGE = 2'h1,
        OP_MASS = 2'h2
    } fmc_op_t;

    typedef enum logic [1:0] {
        SZ_4K = 2'h0,
        SZ_2K = 2'h1,
        SZ_1K = 2'h2
    } fmc_size_t;

endpackage : fmc_pkg

// File: design/fmc_op_timer.sv
`timescale 1ns/1ps
`include "fmc_consts.svh"

module fmc_op_timer (
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic        start,
    input  wire logic [15:0] clockKhz,
    input  wire logic [17:0] durUs,
    output logic             done,
    output logic             running
);
    // duration in cycles is durUs*khz/1000; comparing acc, which gains 1000 per cycle, with durUs*khz
    // avoids a divider and rounds a least time upward
    logic [33:0] target_q, target_d;
    logic [34:0] acc_q, acc_d;
    logic        run_q, run_d;

    always_comb begin
        target_q_next : begin
            target_d = target_q;
            acc_d    = acc_q;
            run_d    = run_q;
            done     = 1'b0;
            if (start) begin
                target_d = 34'(durUs) * 34'(clockKhz);
                acc_d    = 35'(`FMC_HZ_PER_KHZ);
                run_d    = 1'b1;
            end else if (run_q) begin
                if (acc_q >= {1'b0, target_q}) begin
                    done  = 1'b1;
                    run_d = 1'b0;
                end else begin
                    acc_d = acc_q + 35'(`FMC_HZ_PER_KHZ);
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            target_q <= 34'h0;
            acc_q    <= 35'h0;
            run_q    <= 1'b0;
        end else begin
            target_q <= target_d;
            acc_q    <= acc_d;
            run_q    <= run_d;
        end
    end

    assign running = run_q;

endmodule : fmc_op_timer

// File: design/fmc_flash_ctrl.sv
// Function
// - array is made of 512-byte pages; a page is the smallest erase
// - each page holds eight rows of 64 bytes
// - protection sectors are 512 bytes, one sector per page
// - lowest two program bytes hold the option bytes; only byte 0 is loaded after reset
// - program memory starts at zero; ends at 0fff, 07ff or 03ff by size
// - information area fe00 to ffff is readable, never programmed or erased
// - controller drives array strobes and timing for program, page and mass erase
// - write protection by active page, by sector and for whole memory
// - high and low frequency bytes form one 16-bit timing value
// - programmed read-protect option blocks debugger reads of user code
// - locked at reset; page, 73, 8c, same page unlocks; mismatch relocks
// - unlocked 95 erases page if inside program memory and not write-protected; else relock; lock after
// - debugger 63 erases whole array when unlocked; relock after
// - 73 then 5e aims next write at sector bits; bits only set
`timescale 1ns/1ps
`include "fmc_consts.svh"

module fmc_flash_ctrl #(
    parameter int unsigned PAGE_ERASE_US = `FMC_PAGE_ERASE_US,
    parameter int unsigned MASS_ERASE_US = `FMC_MASS_ERASE_US
) (
    input  wire logic              mclk,
    input  wire logic              rst_b,
    input  wire fmc_pkg::fmc_size_t memSize,
    input  wire logic              dbgMode,
    input  wire logic              ctlWr,
    input  wire logic              pageSelWr,
    input  wire logic              freqHiWr,
    input  wire logic              freqLoWr,
    input  wire logic [7:0]        wrData,
    input  wire logic              progReq,
    input  wire logic [15:0]       progAddr,
    input  wire logic [7:0]        progData,
    input  wire logic              dbgRdReq,
    input  wire logic [15:0]       dbgRdAddr,
    input  wire logic [7:0]        arrRdData,
    output logic                   progDeny,
    output logic                   dbgRdDeny,
    output logic [15:0]            flashAddr,
    output logic [7:0]             flashWdata,
    output logic                   flashRead,
    output logic                   flashProg,
    output logic                   flashPageErase,
    output logic                   flashMassErase,
    output logic                   cpuStall,
    output logic                   ctlLocked,
    output logic                   opDone,
    output logic [7:0]             sectorProtect,
    output logic [15:0]            flash_clock_khz,
    output logic                   read_protect_option
);
    import fmc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // decoding shared by program and erase checks

    function automatic logic [3:0] pagesOf(input fmc_size_t sz);
        unique case (sz)
            SZ_2K:   pagesOf = `FMC_PAGES_2K;
            SZ_1K:   pagesOf = `FMC_PAGES_1K;
            default: pagesOf = `FMC_PAGES_4K;
        endcase
    endfunction : pagesOf

    function automatic logic [15:0] endOf(input fmc_size_t sz);
        unique case (sz)
            SZ_2K:   endOf = `FMC_END_2K;
            SZ_1K:   endOf = `FMC_END_1K;
            default: endOf = `FMC_END_4K;
        endcase
    endfunction : endOf

    fmc_state_t  state_q, state_d;
    fmc_op_t     op_q, op_d;
    logic [6:0]  pageFirst_q, pageFirst_d;
    logic [6:0]  activePage_q, activePage_d;
    logic [7:0]  sectProt_q, sectProt_d;
    logic [15:0] khz_q, khz_d;
    logic [7:0]  opt0_q, opt0_d;
    logic [15:0] addr_q, addr_d;
    logic [7:0]  wdata_q, wdata_d;
    logic        prog_q, prog_d;
    logic        pErase_q, pErase_d;
    logic        mErase_q, mErase_d;
    logic        done_q, done_d;
    logic        tmrStart;
    logic        tmrDone;
    logic [17:0] tmrDur;
    logic        pageOk;
    logic        progOk;
    logic        wholeOk;

    ////////////////////////////////////////////////////////////////////////////
    // protection checks

    // whole memory: write-protect option, ignored from the debugger
    assign wholeOk = dbgMode || opt0_q[`FMC_OPT_WP_BIT];
    // sector index equals page index since sector and page are one size
    assign pageOk  = ({1'b0, activePage_q} < {4'h0, pagesOf(memSize)})
                     && !sectProt_q[activePage_q[2:0]] && wholeOk;
    assign progOk  = pageOk && (progAddr <= endOf(memSize))
                     && (progAddr < `FMC_INFO_BASE)
                     && (progAddr[15:`FMC_PAGE_SHIFT] == activePage_q);

    assign progDeny  = progReq && !(state_q == ST_UNLOCKED && progOk);
    // option byte bit programmed to zero means protected
    assign read_protect_option = !opt0_q[`FMC_OPT_RP_BIT];
    assign dbgRdDeny = dbgRdReq && dbgMode && read_protect_option
                       && (dbgRdAddr < `FMC_INFO_BASE);

    ////////////////////////////////////////////////////////////////////////////
    // sequencer

    always_comb begin
        state_d      = state_q;
        op_d         = op_q;
        pageFirst_d  = pageFirst_q;
        activePage_d = activePage_q;
        sectProt_d   = sectProt_q;
        khz_d        = khz_q;
        opt0_d       = opt0_q;
        addr_d       = addr_q;
        wdata_d      = wdata_q;
        prog_d       = prog_q;
        pErase_d     = pErase_q;
        mErase_d     = mErase_q;
        done_d       = 1'b0;
        tmrStart     = 1'b0;
        if (freqHiWr) khz_d[15:8] = wrData;
        if (freqLoWr) khz_d[7:0]  = wrData;
        unique case (state_q)
            ST_OPT0: begin
                addr_d  = 16'h0000;
                state_d = ST_OPT1;
            end
            ST_OPT1: begin
                // second option byte is not decoded here yet
                addr_d  = 16'h0001;
                opt0_d  = arrRdData;
                state_d = ST_OPT2;
            end
            ST_OPT2: begin
                state_d = ST_LOCKED;
            end
            ST_LOCKED: begin
                if (pageSelWr) pageFirst_d = wrData[6:0];
                if (ctlWr && wrData == `FMC_CMD_UNLOCK1) state_d = ST_GOT73;
            end
            ST_GOT73: begin
                if (ctlWr) begin
                    if (wrData == `FMC_CMD_UNLOCK2) state_d = ST_GOT8C;
                    else if (wrData == `FMC_CMD_PROTSEL) state_d = ST_PROTSEL;
                    else state_d = ST_LOCKED;
                end
            end
            ST_GOT8C: begin
                if (ctlWr) begin
                    state_d = ST_LOCKED;
                end else if (pageSelWr) begin
                    if (wrData[6:0] == pageFirst_q) begin
                        activePage_d = wrData[6:0];
                        state_d      = ST_UNLOCKED;
                    end else begin
                        state_d = ST_LOCKED;
                    end
                end
            end
            ST_PROTSEL: begin
                // sticky until reset: bits can be set, never cleared
                if (ctlWr) begin
                    sectProt_d = sectProt_q | wrData;
                    state_d    = ST_LOCKED;
                end
            end
            ST_UNLOCKED: begin
                if (ctlWr) begin
                    state_d = ST_LOCKED;
                    if (wrData == `FMC_CMD_PAGE_ERASE && pageOk) begin
                        addr_d   = {activePage_q, 3'h0, 6'h00}; // row 0, byte 0
                        pErase_d = 1'b1;
                        op_d     = OP_PAGE;
                        tmrStart = 1'b1;
                        state_d  = ST_BUSY;
                    end else if (wrData == `FMC_CMD_MASS_ERASE && dbgMode) begin
                        addr_d   = 16'h0000;
                        mErase_d = 1'b1;
                        op_d     = OP_MASS;
                        tmrStart = 1'b1;
                        state_d  = ST_BUSY;
                    end
                end else if (progReq && progOk) begin
                    addr_d   = progAddr;
                    wdata_d  = progData;
                    prog_d   = 1'b1;
                    op_d     = OP_PROG;
                    tmrStart = 1'b1;
                    state_d  = ST_BUSY;
                end
            end
            ST_BUSY: begin
                if (tmrDone) begin
                    prog_d   = 1'b0;
                    pErase_d = 1'b0;
                    mErase_d = 1'b0;
                    done_d   = 1'b1;
                    // page stays open after a byte, erases relock
                    state_d  = (op_q == OP_PROG) ? ST_UNLOCKED : ST_LOCKED;
                end
            end
        endcase
    end

    always_comb begin
        unique case (op_d)
            OP_PAGE: tmrDur = 18'(PAGE_ERASE_US);
            OP_MASS: tmrDur = 18'(MASS_ERASE_US);
            default: tmrDur = 18'(`FMC_PROG_US);
        endcase
    end

    // software must have loaded a valid khz value before starting
    fmc_op_timer u_timer (
        .mclk    (mclk),
        .rst_b   (rst_b),
        .start   (tmrStart),
        .clockKhz(khz_q),
        .durUs   (tmrDur),
        .done    (tmrDone),
        .running ()
    );

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state_q      <= ST_OPT0;
            op_q         <= OP_PROG;
            pageFirst_q  <= 7'h00;
            activePage_q <= 7'h00;
            sectProt_q   <= 8'h00;
            khz_q        <= 16'h0000;
            opt0_q       <= `FMC_OPT_RESET;
            addr_q       <= 16'h0000;
            wdata_q      <= 8'hff;
            prog_q       <= 1'b0;
            pErase_q     <= 1'b0;
            mErase_q     <= 1'b0;
            done_q       <= 1'b0;
        end else begin
            state_q      <= state_d;
            op_q         <= op_d;
            pageFirst_q  <= pageFirst_d;
            activePage_q <= activePage_d;
            sectProt_q   <= sectProt_d;
            khz_q        <= khz_d;
            opt0_q       <= opt0_d;
            addr_q       <= addr_d;
            wdata_q      <= wdata_d;
            prog_q       <= prog_d;
            pErase_q     <= pErase_d;
            mErase_q     <= mErase_d;
            done_q       <= done_d;
        end
    end

    assign flashAddr       = addr_q;
    assign flashWdata      = wdata_q;
    assign flashRead       = state_q == ST_OPT0 || state_q == ST_OPT1;
    assign flashProg       = prog_q;
    assign flashPageErase  = pErase_q;
    assign flashMassErase  = mErase_q;
    assign cpuStall        = state_q == ST_BUSY;
    assign ctlLocked       = state_q != ST_UNLOCKED && state_q != ST_BUSY;
    assign opDone          = done_q;
    assign sectorProtect   = sectProt_q;
    assign flash_clock_khz = khz_q;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    a_reset_locked : assert property (@(posedge mclk)
        $rose(rst_b) |-> ##3 state_q == ST_LOCKED)
        else $error("controller not locked after option load");
    a_unlock_seq : assert property (@(posedge mclk) disable iff (!rst_b)
        state_q == ST_GOT8C && pageSelWr && !ctlWr && wrData[6:0] == pageFirst_q
        |=> state_q == ST_UNLOCKED)
        else $error("matching page did not unlock");
    a_page_mismatch : assert property (@(posedge mclk) disable iff (!rst_b)
        state_q == ST_GOT8C && pageSelWr && !ctlWr && wrData[6:0] != pageFirst_q
        |=> state_q == ST_LOCKED)
        else $error("page mismatch did not relock");
    a_erase_prot : assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(pErase_q) |-> !sectProt_q[activePage_q[2:0]])
        else $error("protected sector erased");
    a_bad_cmd : assert property (@(posedge mclk) disable iff (!rst_b)
        state_q == ST_UNLOCKED && ctlWr && wrData != `FMC_CMD_PAGE_ERASE
        && wrData != `FMC_CMD_MASS_ERASE |=> state_q == ST_LOCKED)
        else $error("other command did not relock");
    a_mass_dbg : assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(mErase_q) |-> $past(dbgMode))
        else $error("mass erase outside debug");
    a_erase_relock : assert property (@(posedge mclk) disable iff (!rst_b)
        (pErase_q || mErase_q) && tmrDone |=> state_q == ST_LOCKED && opDone)
        else $error("no relock after erase");
    a_sect_sticky : assert property (@(posedge mclk) disable iff (!rst_b)
        ($past(sectProt_q) & ~sectProt_q) == 8'h00)
        else $error("sector protect bit cleared");
    a_info_ro : assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(prog_q) |-> addr_q < `FMC_INFO_BASE && addr_q <= endOf(memSize))
        else $error("program outside program memory");
    a_stall_busy : assert property (@(posedge mclk) disable iff (!rst_b)
        (prog_q || pErase_q || mErase_q) |-> cpuStall)
        else $error("processor not stalled during operation");
    a_rd_protect : assert property (@(posedge mclk) disable iff (!rst_b)
        dbgRdReq && dbgMode && !opt0_q[`FMC_OPT_RP_BIT] && dbgRdAddr < 16'h1000
        |-> dbgRdDeny)
        else $error("protected debugger read allowed");
    a_prog_page : assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(prog_q) |-> addr_q[15:9] == activePage_q ##1 !ctlLocked [*1])
        else $error("program outside active page");

    c_unlock  : cover property (@(posedge mclk) disable iff (!rst_b)
        state_q == ST_GOT8C ##1 state_q == ST_UNLOCKED);
    c_page_er : cover property (@(posedge mclk) disable iff (!rst_b)
        $fell(pErase_q));
    c_prog    : cover property (@(posedge mclk) disable iff (!rst_b)
        $fell(prog_q) ##1 state_q == ST_UNLOCKED);
    c_protect : cover property (@(posedge mclk) disable iff (!rst_b)
        sectProt_q != $past(sectProt_q));

endmodule : fmc_flash_ctrl

// File: tb/fmc_array_model.sv
`timescale 1ns/1ps
module fmc_array_model (
    input  wire logic        mclk,
    input  wire logic        flashRead,
    input  wire logic [15:0] flashAddr,
    input  wire logic [7:0]  optByte0,
    output logic [7:0]       arrRdData
);
    // read data lands one cycle after the address; outside reads the bus
    // toggles so that a stale byte is never taken for an option byte
    always_ff @(posedge mclk) begin
        if (flashRead) begin
            arrRdData <= (flashAddr == 16'h0000) ? optByte0 : 8'hff;
        end else begin
            arrRdData <= (arrRdData === 8'h5a) ? 8'ha5 : 8'h5a;
        end
    end
endmodule : fmc_array_model

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import fmc_pkg::*;
`define CHK(nm, ex, got) begin checksDone++; if ((got) !== (ex)) begin errTotal++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
    logic mclk, rst_b, dbgMode, ctlWr, pageSelWr, freqHiWr, freqLoWr, progReq, dbgRdReq;
    logic [7:0]  wrData, progData, arrRdData, optByte0, sectorProtect, flashWdata;
    logic [15:0] progAddr, dbgRdAddr, flashAddr, flash_clock_khz;
    logic progDeny, dbgRdDeny, flashRead, flashProg, flashPageErase, flashMassErase;
    logic cpuStall, ctlLocked, opDone, read_protect_option, deny;
    fmc_size_t memSize;
    int   errTotal, checksDone, n;

    fmc_flash_ctrl #(.PAGE_ERASE_US(2), .MASS_ERASE_US(2)) uut (
        .mclk(mclk), .rst_b(rst_b), .memSize(memSize), .dbgMode(dbgMode), .ctlWr(ctlWr),
        .pageSelWr(pageSelWr), .freqHiWr(freqHiWr), .freqLoWr(freqLoWr), .wrData(wrData),
        .progReq(progReq), .progAddr(progAddr), .progData(progData), .dbgRdReq(dbgRdReq),
        .dbgRdAddr(dbgRdAddr), .arrRdData(arrRdData), .progDeny(progDeny),
        .dbgRdDeny(dbgRdDeny), .flashAddr(flashAddr), .flashWdata(flashWdata),
        .flashRead(flashRead), .flashProg(flashProg), .flashPageErase(flashPageErase),
        .flashMassErase(flashMassErase), .cpuStall(cpuStall), .ctlLocked(ctlLocked),
        .opDone(opDone), .sectorProtect(sectorProtect), .flash_clock_khz(flash_clock_khz),
        .read_protect_option(read_protect_option));
    fmc_array_model partner (.mclk(mclk), .flashRead(flashRead), .flashAddr(flashAddr),
        .optByte0(optByte0), .arrRdData(arrRdData));

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("checks %0d mismatches %0d", checksDone, errTotal);
        if (errTotal == 0 && checksDone > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude

    // kind: 0 control, 1 page select, 2 khz high, 3 khz low
    task automatic wr(input int kind, input logic [7:0] d);
        @(posedge mclk);
        wrData <= d;
        ctlWr <= (kind == 0);
        pageSelWr <= (kind == 1);
        freqHiWr <= (kind == 2);
        freqLoWr <= (kind == 3);
        @(posedge mclk);
        {ctlWr, pageSelWr, freqHiWr, freqLoWr} <= 4'h0;
        @(negedge mclk);
    endtask : wr

    task automatic unlock(input logic [7:0] p1, input logic [7:0] p2);
        wr(1, p1);
        wr(0, 8'h73);
        wr(0, 8'h8c);
        wr(1, p2);
    endtask : unlock

    task automatic prog(input logic [15:0] a, input logic [7:0] d, output logic dn);
        @(posedge mclk);
        progReq <= 1'b1;
        progAddr <= a;
        progData <= d;
        @(negedge mclk);
        dn = progDeny;
        @(posedge mclk);
        progReq <= 1'b0;
        @(negedge mclk);
    endtask : prog

    // bounded wait for the end-of-operation pulse, counted in cycles
    task automatic waitDone(output int cyc);
        cyc = 0;
        while (opDone !== 1'b1) begin
            @(negedge mclk);
            cyc++;
            if (cyc > 400) begin
                errTotal++;
                $display("CHECK FAILED opDone expected 1 seen %b", opDone);
                conclude();
            end
        end
        @(negedge mclk);
    endtask : waitDone

    task automatic doRst(input logic [7:0] opt);
        @(posedge mclk);
        optByte0 <= opt;
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
    endtask : doRst

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic scReset;
        `CHK("locked", 1'b1, ctlLocked)
        `CHK("stall", 1'b0, cpuStall)
        `CHK("sectors", 8'h00, sectorProtect)
        `CHK("rdProt", 1'b0, read_protect_option)
        wr(2, 8'h03); // khz chosen inside the supported clock range
        wr(3, 8'he8);
        `CHK("khz", 16'h03e8, flash_clock_khz)
    endtask : scReset

    task automatic scProgram;
        unlock(8'h01, 8'h01);
        `CHK("unlocked", 1'b0, ctlLocked)
        prog(16'h0205, 8'h3c, deny);
        `CHK("progDeny", 1'b0, deny)
        `CHK("flashProg", 1'b1, flashProg)
        `CHK("stall", 1'b1, cpuStall)
        `CHK("addr", 16'h0205, flashAddr)
        `CHK("wdata", 8'h3c, flashWdata)
        waitDone(n);
        // 40 us at 1000 khz is 40 cycles, plus a little pipeline slack
        `CHK("progTime", 1'b1, (n >= 38 && n <= 44))
        `CHK("released", 1'b0, cpuStall)
        `CHK("stillOpen", 1'b0, ctlLocked)
        prog(16'h0405, 8'h11, deny);
        `CHK("otherPage", 1'b1, deny)
        wr(0, 8'h00);
        `CHK("relock", 1'b1, ctlLocked)
    endtask : scProgram

    task automatic scRefuse;
        unlock(8'h01, 8'h02);
        `CHK("mismatch", 1'b1, ctlLocked)
        unlock(8'h08, 8'h08);
        prog(16'h1000, 8'h00, deny);
        `CHK("pastEnd", 1'b1, deny)
        wr(0, 8'h00);
        unlock(8'h7f, 8'h7f);
        prog(16'hfe00, 8'h00, deny);
        `CHK("infoProg", 1'b1, deny)
        wr(0, 8'h95);
        `CHK("infoErase", 1'b0, flashPageErase)
        `CHK("noStall", 1'b0, cpuStall)
        // smaller variants: 1k last byte accepted, next page refused for 1k and 2k
        @(posedge mclk);
        memSize <= SZ_1K;
        unlock(8'h01, 8'h01);
        prog(16'h03ff, 8'h5a, deny);
        `CHK("end1k", 1'b0, deny)
        waitDone(n);
        wr(0, 8'h00);
        unlock(8'h02, 8'h02);
        prog(16'h0400, 8'h00, deny);
        `CHK("past1k", 1'b1, deny)
        wr(0, 8'h00);
        @(posedge mclk);
        memSize <= SZ_2K;
        unlock(8'h04, 8'h04);
        prog(16'h0800, 8'h00, deny);
        `CHK("past2k", 1'b1, deny)
        wr(0, 8'h00);
        @(posedge mclk);
        memSize <= SZ_4K;
    endtask : scRefuse

    task automatic scErase;
        unlock(8'h02, 8'h02);
        wr(0, 8'h95);
        `CHK("pageErase", 1'b1, flashPageErase)
        `CHK("eraseAddr", 16'h0400, flashAddr)
        `CHK("stall", 1'b1, cpuStall)
        waitDone(n);
        `CHK("eraseEnd", 1'b0, flashPageErase)
        `CHK("relock", 1'b1, ctlLocked)
    endtask : scErase

    task automatic scProtect;
        wr(0, 8'h73);
        wr(0, 8'h5e);
        wr(0, 8'h04);
        `CHK("setBit", 8'h04, sectorProtect)
        wr(0, 8'h73);
        wr(0, 8'h5e);
        wr(0, 8'h00);
        `CHK("noClear", 8'h04, sectorProtect)
        unlock(8'h02, 8'h02);
        prog(16'h0400, 8'h00, deny);
        `CHK("protProg", 1'b1, deny)
        wr(0, 8'h95);
        `CHK("protErase", 1'b0, flashPageErase)
        `CHK("protLock", 1'b1, ctlLocked)
    endtask : scProtect

    task automatic scMass;
        unlock(8'h00, 8'h00);
        wr(0, 8'h63);
        `CHK("userMass", 1'b0, flashMassErase)
        `CHK("userLock", 1'b1, ctlLocked)
        @(posedge mclk);
        dbgMode <= 1'b1;
        unlock(8'h00, 8'h00);
        wr(0, 8'h63);
        `CHK("massErase", 1'b1, flashMassErase)
        `CHK("stall", 1'b1, cpuStall)
        waitDone(n);
        `CHK("massLock", 1'b1, ctlLocked)
    endtask : scMass

    task automatic scReadProt;
        @(posedge mclk);
        dbgRdReq <= 1'b1;
        dbgRdAddr <= 16'h0100;
        @(negedge mclk);
        `CHK("openRead", 1'b0, dbgRdDeny)
        doRst(8'h7f);
        `CHK("rdProt", 1'b1, read_protect_option)
        `CHK("rstSectors", 8'h00, sectorProtect)
        `CHK("userRead", 1'b1, dbgRdDeny)
        @(posedge mclk);
        dbgRdAddr <= 16'hfe00;
        @(negedge mclk);
        `CHK("infoRead", 1'b0, dbgRdDeny)
        @(posedge mclk);
        dbgRdAddr <= 16'h0100;
        dbgMode <= 1'b0;
        @(negedge mclk);
        `CHK("cpuRead", 1'b0, dbgRdDeny)
        `CHK("rdIdle", 1'b0, flashRead)
        // write-protect option programmed: user code may not program at all
        doRst(8'hbf);
        `CHK("wpOpt", 1'b0, read_protect_option)
        unlock(8'h00, 8'h00);
        prog(16'h0010, 8'h00, deny);
        `CHK("wholeProt", 1'b1, deny)
    endtask : scReadProt

    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    initial begin
        repeat (30000) @(posedge mclk);
        errTotal++;
        $display("CHECK FAILED watchdog expected finish seen hang");
        conclude();
    end

    initial begin
        {rst_b, dbgMode, ctlWr, pageSelWr, freqHiWr, freqLoWr, progReq, dbgRdReq} = 8'h00;
        wrData = 8'h00;
        progData = 8'h00;
        progAddr = 16'h0000;
        dbgRdAddr = 16'h0000;
        optByte0 = 8'hff;
        memSize = SZ_4K;
        errTotal = 0;
        checksDone = 0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        scReset();
        scProgram();
        scRefuse();
        scErase();
        scProtect();
        scMass();
        scReadProt();
        conclude();
    end
endmodule : tb_top
